// >>> rtl/cps_pkg.sv
package cps_pkg;

  // clock and counter width
  localparam longint unsigned CLK_HZ = 64'd100_000_000;
  localparam int              TW     = 48;

  // times as printed, then cycle counts (least times round up)
  localparam longint unsigned T_BIAS_MS   = 64'd220;
  localparam longint unsigned T_RETRY_MS  = 64'd2000;
  localparam longint unsigned T_BOOST_MS  = 64'd30;
  localparam longint unsigned T_SAFETY_H  = 64'd10;
  localparam longint unsigned T_KA1_S     = 64'd40;
  localparam longint unsigned T_KA2_S     = 64'd80;
  localparam longint unsigned T_KA3_S     = 64'd160;
  localparam logic [TW-1:0] BIAS_CYC   = TW'((T_BIAS_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam logic [TW-1:0] RETRY_CYC  = TW'((T_RETRY_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam logic [TW-1:0] BOOST_CYC  = TW'((T_BOOST_MS * CLK_HZ + 64'd999) / 64'd1000);
  localparam logic [TW-1:0] SAFETY_CYC = TW'(T_SAFETY_H * 64'd3600 * CLK_HZ);
  localparam logic [TW-1:0] KA1_CYC    = TW'(T_KA1_S * CLK_HZ);
  localparam logic [TW-1:0] KA2_CYC    = TW'(T_KA2_S * CLK_HZ);
  localparam logic [TW-1:0] KA3_CYC    = TW'(T_KA3_S * CLK_HZ);
  localparam logic [3:0]    BOOST_PFM_CYC = 4'hf;

  // limit codes: current in 100 mA steps, voltage in 100 mV steps
  localparam logic [5:0] ICL_RST   = 6'h05;
  localparam logic [5:0] ICL_USB   = 6'h05;
  localparam logic [5:0] ICL_ADAPT = 6'h18;
  localparam logic [5:0] ICL_SOFT  = 6'h02;
  localparam logic [5:0] VIL_RST   = 6'h2d;
  localparam logic [5:0] TRK_OFF1  = 6'h02;
  localparam logic [5:0] TRK_OFF2  = 6'h03;
  localparam logic [5:0] TRK_OFF3  = 6'h04;

  // source-type codes
  localparam logic [2:0] SRC_NONE  = 3'h0;
  localparam logic [2:0] SRC_USB   = 3'h1;
  localparam logic [2:0] SRC_ADAPT = 3'h3;
  localparam logic [2:0] SRC_BOOST = 3'h7;

  typedef enum logic [3:0] {
    SQ_HIZ, SQ_BIAS, SQ_QUAL, SQ_RETRY, SQ_DETECT, SQ_VLIM, SQ_RUN,
    SQ_BWAIT, SQ_BPFM, SQ_BRUN
  } cps_seq_t;

  // comparator and pin levels from the analog side
  typedef struct packed {
    logic inputPresent;
    logic notSleep;
    logic overVoltage;
    logic minVoltOk;
    logic busUvloOk;
    logic batUvloOk;
    logic batDeplOk;
    logic batOcp;
    logic select;
    logic sysAbove;
    logic lightLoad;
    logic batBelowMin;
    logic batAboveBoost;
    logic thermOk;
  } cps_pins_t;

  // host-written configuration
  typedef struct packed {
    logic       chargeEnable;
    logic       boostEnable;
    logic       boostCurrentSelect;
    logic       lightLoadModeDisable;
    logic [1:0] limitTrackingOffset;
    logic [1:0] timeoutPeriod;
    logic       batterySwitchResetEn;
    logic       batterySwitchDelay;
  } cps_cfg_t;

  localparam cps_cfg_t CFG_RST = '{chargeEnable: 1'b1, boostEnable: 1'b0,
    boostCurrentSelect: 1'b0, lightLoadModeDisable: 1'b0, limitTrackingOffset: 2'h0,
    timeoutPeriod: 2'h1, batterySwitchResetEn: 1'b1, batterySwitchDelay: 1'b0};

  // status seen by the host and the power stage
  typedef struct packed {
    logic       biasRegulatorOn;
    logic       highImpedanceState;
    logic       qualLoadOn;
    logic       batterySwitchOn;
    logic       batterySwitchOffFlag;
    logic       inputGoodFlag;
    logic       powerGoodFlag;
    logic [2:0] sourceTypeField;
    logic       intPulse;
    logic       converterOn;
    logic       chargeActive;
    logic       pfmMode;
    logic       boostOn;
    logic       boostCurrentSelect;
    logic       hostTimeoutFlag;
    logic       i2cReady;
    logic [5:0] inputCurrentLimit;
    logic [5:0] effCurrentLimit;
    logic [5:0] inputVoltageLimit;
    logic [5:0] effVoltageLimit;
  } cps_stat_t;

endpackage

// >>> rtl/cps_timer.sv
`timescale 1ns/10ps
module cps_timer
  import cps_pkg::*;
#(
  parameter int W = TW
) (
  input  wire logic         clock,
  input  wire logic         nrst,
  input  wire logic         clockEn,
  input  wire logic         start,
  input  wire logic         stop,
  input  wire logic [W-1:0] period,
  output logic              running,
  output logic              done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         run;
    logic         done;
  } cps_tmr_t;

  cps_tmr_t r;
  cps_tmr_t next_r;

  // stop beats start; done pulses one edge after the last count
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (stop) begin
      next_r.run = 1'b0;
    end else if (start) begin
      next_r.cnt = (period == '0) ? W'(1) : period;
      next_r.run = 1'b1;
    end else if (r.run) begin
      if (r.cnt <= W'(1)) begin
        next_r.run  = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.cnt = r.cnt - W'(1);
      end
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
    end else if (clockEn) begin
      r <= next_r;
    end
  end

  assign running = r.run;
  assign done    = r.done;

endmodule

// >>> rtl/cps_sequencer.sv
// Contract
// - supply above undervoltage release enables host port and restores all defaults
// - battery alone above depletion closes battery switch, bias regulator off
// - discharge overcurrent opens switch, sets off flag until input returns or re-enable
// - input attach runs bias, qualify, detect, voltage limit, converter, in order
// - bias regulator needs input present, not asleep, and 220 ms elapsed; code also turns it on in boost (SQ_BPFM, SQ_BRUN)
// - qualification pass sets input-good flag and pulses host interrupt
// - failed qualification is retried every 2 seconds
// - detection end pulses interrupt, loads current limit, power-good, source type
// - host may overwrite current limit anytime; input capped at that value
// - select high gives 500 mA code 001; low gives 2.4 A code 011
// - default mode follows select pin live; host mode needs force-detect
// - voltage limit defaults 4.5 V; tracking takes max with battery plus offset
// - converter starts after limit set; switch opens when charging disabled or off flag set
// - system rail below 2.2 V caps current at min of 200 mA and limit
// - light load, low battery or charge off gives pulse mode unless disabled
// - boost starts on battery, sleep, enable bit, thermistor ok, after 30 ms
// - boost reports source type 111 and uses boost current select
// - boost starts in pulse mode then fixed frequency, held while battery good
// - reset starts in default mode; timeout flag high in default, low in host
// - default mode runs 10-hour charge timer; expiry stops charge, converter runs
// - keep-alive write enters host mode; host repeats it or sets period 00
// - keep-alive timeout reverts to default, resets registers except the kept ones
`timescale 1ns/10ps
module cps_sequencer
  import cps_pkg::*;
#(
  parameter logic [TW-1:0] BIAS_CYCLES   = BIAS_CYC,
  parameter logic [TW-1:0] RETRY_CYCLES  = RETRY_CYC,
  parameter logic [TW-1:0] BOOST_CYCLES  = BOOST_CYC,
  parameter logic [TW-1:0] SAFETY_CYCLES = SAFETY_CYC,
  parameter logic [TW-1:0] KA1_CYCLES    = KA1_CYC,
  parameter logic [TW-1:0] KA2_CYCLES    = KA2_CYC,
  parameter logic [TW-1:0] KA3_CYCLES    = KA3_CYC
) (
  input  wire logic       clock,
  input  wire logic       nrst,
  input  wire logic       clockEn,
  input  wire cps_pins_t  pins,
  input  wire logic [5:0] batteryVoltage,
  input  wire logic       cfgWr,
  input  wire cps_cfg_t   cfgData,
  input  wire logic       iclWr,
  input  wire logic [5:0] iclData,
  input  wire logic       vilWr,
  input  wire logic [5:0] vilData,
  input  wire logic       keepaliveBit,
  input  wire logic       forceDetectBit,
  input  wire logic       batterySwitchReEnable,
  output cps_stat_t       stat,
  output cps_cfg_t        cfg
);

  typedef struct packed {
    cps_pins_t  sync1;
    cps_pins_t  sync2;
    cps_pins_t  sync3;
    cps_pins_t  filt;
    cps_seq_t   seq;
    cps_cfg_t   cfg;
    logic [2:0] srcType;
    logic       hostMode;
    logic       safetyExpired;
    logic       selPrev;
    logic       inPrev;
    logic [3:0] pfmCnt;
    cps_stat_t  stat;
  } cps_state_t;

  cps_state_t      r;
  cps_state_t      next_r;
  logic            seqStart;
  logic            seqStop;
  logic [TW-1:0]   seqPeriod;
  logic            seqDone;
  logic            kaStart;
  logic            kaStop;
  logic            kaDone;
  logic            sfStart;
  logic            sfStop;
  logic            sfDone;
  logic            sfRunning;
  logic            inputOk;
  logic            qualPass;
  logic            boostOk;
  logic            supplyUp;
  logic            chargeCond;

  // pin level to limit and source code
  function automatic logic [5:0] selLimit(input logic sel);
    return sel ? ICL_USB : ICL_ADAPT;
  endfunction

  function automatic logic [2:0] selType(input logic sel);
    return sel ? SRC_USB : SRC_ADAPT;
  endfunction

  function automatic logic [5:0] umin(input logic [5:0] a, input logic [5:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [5:0] umax(input logic [5:0] a, input logic [5:0] b);
    return (a > b) ? a : b;
  endfunction

  // tracked limit; sum saturates rather than wrapping to a low limit
  function automatic logic [5:0] trackLimit(input logic [5:0] vil, input logic [5:0] bat,
                                             input logic [1:0] sel);
    logic [6:0] sum;
    sum = 7'h00;
    case (sel)
      2'h1:    sum = {1'b0, bat} + {1'b0, TRK_OFF1};
      2'h2:    sum = {1'b0, bat} + {1'b0, TRK_OFF2};
      2'h3:    sum = {1'b0, bat} + {1'b0, TRK_OFF3};
      default: sum = {1'b0, vil};
    endcase
    return umax(vil, sum[6] ? 6'h3f : sum[5:0]);
  endfunction

  function automatic logic [TW-1:0] kaPeriod(input logic [1:0] sel);
    case (sel)
      2'h1:    return KA1_CYCLES;
      2'h2:    return KA2_CYCLES;
      default: return KA3_CYCLES;
    endcase
  endfunction

  // filtered comparator levels only; sync1 feeds nothing else
  assign supplyUp   = r.filt.busUvloOk | r.filt.batUvloOk;
  assign inputOk    = r.filt.inputPresent & r.filt.notSleep;
  assign qualPass   = ~r.filt.overVoltage & r.filt.minVoltOk;
  assign boostOk    = r.filt.batAboveBoost & ~r.filt.notSleep & r.cfg.boostEnable
                    & r.filt.thermOk;
  assign chargeCond = (r.seq == SQ_RUN) & ~r.hostMode & r.cfg.chargeEnable;

  // keep-alive timer, period chosen by the timeout field
  assign kaStart = keepaliveBit & supplyUp & (r.cfg.timeoutPeriod != 2'h0);
  assign kaStop  = ~supplyUp | (r.cfg.timeoutPeriod == 2'h0);

  // safety timer only while charging in default mode
  assign sfStart = chargeCond & ~sfRunning & ~r.safetyExpired;
  assign sfStop  = ~chargeCond;

  cps_timer #(.W(TW)) u_seqTimer (
    .clock   (clock),
    .nrst    (nrst),
    .clockEn (clockEn),
    .start   (seqStart),
    .stop    (seqStop),
    .period  (seqPeriod),
    .running (),
    .done    (seqDone)
  );

  cps_timer #(.W(TW)) u_kaTimer (
    .clock   (clock),
    .nrst    (nrst),
    .clockEn (clockEn),
    .start   (kaStart),
    .stop    (kaStop),
    .period  (kaPeriod(r.cfg.timeoutPeriod)),
    .running (),
    .done    (kaDone)
  );

  cps_timer #(.W(TW)) u_safetyTimer (
    .clock   (clock),
    .nrst    (nrst),
    .clockEn (clockEn),
    .start   (sfStart),
    .stop    (sfStop),
    .period  (SAFETY_CYCLES),
    .running (sfRunning),
    .done    (sfDone)
  );

  // all next-state logic
  always_comb begin
    next_r    = r;
    seqStart  = 1'b0;
    seqStop   = 1'b0;
    seqPeriod = BIAS_CYCLES;
    next_r.sync1 = pins;
    next_r.sync2 = r.sync1;
    next_r.sync3 = r.sync2;
    // a bit moves only once the last two stages agree
    next_r.filt  = cps_pins_t'((r.sync2 & r.sync3) | (r.filt & (r.sync2 ^ r.sync3)));
    next_r.selPrev = r.filt.select;
    next_r.inPrev  = r.filt.inputPresent;
    next_r.stat.intPulse = 1'b0;

    // start-up sequence
    case (r.seq)
      SQ_HIZ: begin
        if (inputOk) begin
          seqStart   = 1'b1;
          seqPeriod  = BIAS_CYCLES;
          next_r.seq = SQ_BIAS;
        end else if (boostOk) begin
          seqStart   = 1'b1;
          seqPeriod  = BOOST_CYCLES;
          next_r.seq = SQ_BWAIT;
        end
      end
      SQ_BIAS: begin
        if (seqDone) begin
          next_r.seq = SQ_QUAL;
        end
      end
      SQ_QUAL: begin
        if (qualPass) begin
          next_r.stat.inputGoodFlag = 1'b1;
          next_r.stat.intPulse      = 1'b1;
          next_r.seq                = SQ_DETECT;
        end else begin
          seqStart   = 1'b1;
          seqPeriod  = RETRY_CYCLES;
          next_r.seq = SQ_RETRY;
        end
      end
      SQ_RETRY: begin
        if (seqDone) begin
          next_r.seq = SQ_QUAL;
        end
      end
      SQ_DETECT: begin
        next_r.stat.inputCurrentLimit = selLimit(r.filt.select);
        next_r.srcType                = selType(r.filt.select);
        next_r.stat.powerGoodFlag     = 1'b1;
        next_r.stat.intPulse          = 1'b1;
        next_r.seq                    = SQ_VLIM;
      end
      SQ_VLIM: begin
        next_r.seq = SQ_RUN;
      end
      SQ_RUN: begin
        // default mode tracks pin changes; host mode waits for force-detect
        if ((!r.hostMode && (r.filt.select != r.selPrev)) ||
            (r.hostMode && forceDetectBit)) begin
          next_r.stat.inputCurrentLimit = selLimit(r.filt.select);
          next_r.srcType                = selType(r.filt.select);
        end
      end
      SQ_BWAIT: begin
        if (!boostOk) begin
          seqStop    = 1'b1;
          next_r.seq = SQ_HIZ;
        end else if (seqDone) begin
          next_r.pfmCnt = 4'h0;
          next_r.seq    = SQ_BPFM;
        end
      end
      SQ_BPFM: begin
        next_r.pfmCnt = r.pfmCnt + 4'h1;
        if (!boostOk) begin
          next_r.seq = SQ_HIZ;
        end else if (r.pfmCnt == BOOST_PFM_CYC) begin
          next_r.seq = SQ_BRUN;
        end
      end
      SQ_BRUN: begin
        if (!boostOk) begin
          next_r.seq = SQ_HIZ;
        end
      end
      default: begin
        next_r.seq = SQ_HIZ;
      end
    endcase

    // losing the input on the buck path drops straight back to idle
    if (!inputOk && (r.seq inside {SQ_BIAS, SQ_QUAL, SQ_RETRY, SQ_DETECT, SQ_VLIM,
                                   SQ_RUN})) begin
      seqStop                   = 1'b1;
      next_r.seq                = SQ_HIZ;
      next_r.stat.inputGoodFlag = 1'b0;
      next_r.stat.powerGoodFlag = 1'b0;
      next_r.srcType            = SRC_NONE;
    end

    // charge timer expiry holds until the run ends
    next_r.safetyExpired = sfDone | (r.safetyExpired & (next_r.seq == SQ_RUN));

    // keep-alive: write wins over a timeout in the same cycle
    if (keepaliveBit && supplyUp) begin
      next_r.hostMode = 1'b1;
    end else if (kaDone) begin
      next_r.hostMode = 1'b0;
      next_r.cfg      = CFG_RST;
      next_r.cfg.batterySwitchResetEn = r.cfg.batterySwitchResetEn;
      next_r.cfg.batterySwitchDelay   = r.cfg.batterySwitchDelay;
    end
    if (cfgWr) begin
      next_r.cfg = cfgData;
    end
    if (iclWr) begin
      next_r.stat.inputCurrentLimit = iclData;
    end
    if (vilWr) begin
      next_r.stat.inputVoltageLimit = vilData;
    end

    // overcurrent set beats a re-enable or input-return clear in the same cycle
    next_r.stat.batterySwitchOffFlag = r.filt.batOcp |
      (r.stat.batterySwitchOffFlag & ~batterySwitchReEnable &
       ~(r.filt.inputPresent & ~r.inPrev));

    // no supply: config, host mode, both limits and off flag held at default
    if (!supplyUp) begin
      next_r.cfg                       = CFG_RST;
      next_r.hostMode                  = 1'b0;
      next_r.stat.inputCurrentLimit    = ICL_RST;
      next_r.stat.inputVoltageLimit    = VIL_RST;
      next_r.stat.batterySwitchOffFlag = 1'b0;
    end

    // outputs derived from the next state so they leave flops directly
    next_r.stat.i2cReady           = supplyUp;
    next_r.stat.hostTimeoutFlag    = ~next_r.hostMode;
    next_r.stat.biasRegulatorOn    = !(next_r.seq inside {SQ_HIZ, SQ_BIAS, SQ_BWAIT});
    next_r.stat.highImpedanceState = !next_r.stat.biasRegulatorOn;
    next_r.stat.qualLoadOn         = (next_r.seq == SQ_QUAL);
    next_r.stat.converterOn        = (next_r.seq == SQ_RUN);
    next_r.stat.boostOn            = next_r.seq inside {SQ_BPFM, SQ_BRUN};
    next_r.stat.boostCurrentSelect = next_r.cfg.boostCurrentSelect;
    next_r.stat.sourceTypeField    = next_r.stat.boostOn ? SRC_BOOST : next_r.srcType;
    next_r.stat.chargeActive       = next_r.stat.converterOn & next_r.cfg.chargeEnable &
                                     ~next_r.safetyExpired &
                                     ~next_r.stat.batterySwitchOffFlag;
    if (next_r.stat.batterySwitchOffFlag) begin
      next_r.stat.batterySwitchOn = 1'b0;
    end else if (next_r.stat.converterOn) begin
      next_r.stat.batterySwitchOn = next_r.cfg.chargeEnable;
    end else if (next_r.stat.boostOn) begin
      next_r.stat.batterySwitchOn = 1'b1;
    end else begin
      next_r.stat.batterySwitchOn = r.filt.batDeplOk;
    end
    if (next_r.seq == SQ_BPFM) begin
      next_r.stat.pfmMode = ~next_r.cfg.lightLoadModeDisable;
    end else if (next_r.seq == SQ_RUN) begin
      next_r.stat.pfmMode = ~next_r.cfg.lightLoadModeDisable &
        (r.filt.lightLoad | r.filt.batBelowMin | ~next_r.cfg.chargeEnable);
    end else begin
      next_r.stat.pfmMode = 1'b0;
    end
    next_r.stat.effCurrentLimit = r.filt.sysAbove ? next_r.stat.inputCurrentLimit :
      umin(next_r.stat.inputCurrentLimit, ICL_SOFT);
    next_r.stat.effVoltageLimit = trackLimit(next_r.stat.inputVoltageLimit, batteryVoltage,
                                             next_r.cfg.limitTrackingOffset);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      r <= '0;
    end else if (clockEn) begin
      r <= next_r;
    end
  end

  assign stat = r.stat;
  assign cfg  = r.cfg;

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst || !clockEn);

  sequence s_qualOk;
    (r.seq == SQ_QUAL) && qualPass && inputOk && supplyUp;
  endsequence

  sequence s_detectHigh;
    (r.seq == SQ_DETECT) && inputOk && r.filt.select && !iclWr;
  endsequence

  property p_ocpOpens;
    r.filt.batOcp |=> !stat.batterySwitchOn && stat.batterySwitchOffFlag;
  endproperty
  a_ocpOpens: assert property (p_ocpOpens) else $error("switch not opened on overcurrent");

  property p_hizBiasOff;
    stat.highImpedanceState |-> !stat.biasRegulatorOn && !stat.converterOn;
  endproperty
  a_hizBiasOff: assert property (p_hizBiasOff) else $error("bias on in idle");

  property p_qualPass;
    s_qualOk |=> stat.inputGoodFlag && stat.intPulse ##1 stat.powerGoodFlag;
  endproperty
  a_qualPass: assert property (p_qualPass) else $error("qualification pass not flagged");

  property p_retry;
    ((r.seq == SQ_QUAL) && !qualPass && inputOk) |=> (r.seq == SQ_RETRY) && !stat.inputGoodFlag;
  endproperty
  a_retry: assert property (p_retry) else $error("failed qualification not retried");

  property p_detectUsb;
    s_detectHigh |=> (stat.inputCurrentLimit == ICL_USB) && (stat.sourceTypeField == SRC_USB)
                     ##1 stat.converterOn;
  endproperty
  a_detectUsb: assert property (p_detectUsb) else $error("usb detection result wrong");

  property p_softLimit;
    !r.filt.sysAbove |=> stat.effCurrentLimit <= ICL_SOFT;
  endproperty
  a_softLimit: assert property (p_softLimit) else $error("soft-start limit exceeded");

  property p_boostCode;
    stat.boostOn |-> (stat.sourceTypeField == SRC_BOOST) && !stat.converterOn;
  endproperty
  a_boostCode: assert property (p_boostCode) else $error("boost source code wrong");

  property p_keepalive;
    (keepaliveBit && supplyUp) |=> !stat.hostTimeoutFlag;
  endproperty
  a_keepalive: assert property (p_keepalive) else $error("keep-alive did not enter host mode");

  property p_timeoutRevert;
    (kaDone && !keepaliveBit && !cfgWr && !iclWr && !forceDetectBit && supplyUp) |=>
      stat.hostTimeoutFlag && (cfg.timeoutPeriod == CFG_RST.timeoutPeriod)
      && $stable(stat.inputCurrentLimit);
  endproperty
  a_timeoutRevert: assert property (p_timeoutRevert) else $error("timeout revert wrong");

endmodule

// >>> bench/cps_phy_model.sv
`timescale 1ns/10ps
module cps_phy_model (
  input  wire logic clock,
  input  wire logic usbHost,
  output logic      select
);
  // phy pin is registered: a port change lands one edge late, like real logic
  always_ff @(posedge clock) begin
    select <= usbHost;
  end
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/10ps
module tb_top;
  import cps_pkg::*;
  logic       clock   = 1'b0;
  logic       nrst    = 1'b0;
  logic       usbHost = 1'b1;
  logic       phySelect;
  cps_pins_t  pinsDrv;
  cps_pins_t  pinsAll;
  logic [5:0] strb    = '0;
  logic [5:0] sData   = '0;
  logic       clockEn = 1'b1;
  logic [5:0] batV    = 6'h26;
  cps_cfg_t   cfgDrv  = CFG_RST;
  cps_cfg_t   cfgExp;
  cps_stat_t  stat;
  cps_cfg_t   cfg;
  int         errors    = 0;
  int         cmp_count = 0;
  int         i;
  int         biasAt;
  int         nQual;
  int         nInt;

  always #5 clock = ~clock;
  // select pin belongs to the phy, every other level to the bench
  always_comb begin
    pinsAll = pinsDrv;
    pinsAll.select = phySelect;
  end
  cps_phy_model phy (.clock(clock), .usbHost(usbHost), .select(phySelect));
  // short counts keep the run small; expectations use these figures
  cps_sequencer #(.BIAS_CYCLES(48'd20), .RETRY_CYCLES(48'd30), .BOOST_CYCLES(48'd10),
    .SAFETY_CYCLES(48'd200), .KA1_CYCLES(48'd50)) dut (
    .clock(clock), .nrst(nrst), .clockEn(clockEn), .pins(pinsAll), .batteryVoltage(batV),
    .cfgWr(strb[5]), .cfgData(cfgDrv), .iclWr(strb[0]), .iclData(sData), .vilWr(strb[1]),
    .vilData(sData), .keepaliveBit(strb[2]), .batterySwitchReEnable(strb[3]),
    .forceDetectBit(strb[4]), .stat(stat), .cfg(cfg));

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // one-cycle host strobe, then let the answer land
  task automatic strobe(input int k, input logic [5:0] d);
    @(posedge clock);
    strb <= 6'(1 << k);
    sData <= d;
    @(posedge clock);
    strb <= '0;
    settle(2);
  endtask
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    pinsDrv = '0;
    pinsDrv.busUvloOk = 1'b1;
    pinsDrv.batUvloOk = 1'b1;
    pinsDrv.batDeplOk = 1'b1;
    pinsDrv.minVoltOk = 1'b1;
    pinsDrv.sysAbove = 1'b1;
    pinsDrv.batAboveBoost = 1'b1;
    pinsDrv.thermOk = 1'b1;
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    for (i = 0; i < 100 && stat.i2cReady !== 1'b1; i++) settle(1);
    settle(3);
    chk(i < 100, 1'b1);
    chk(cfg, CFG_RST);
    chk(stat.inputCurrentLimit, ICL_RST);
    chk(stat.inputVoltageLimit, VIL_RST);
    chk(stat.hostTimeoutFlag, 1'b1);
    chk(stat.batterySwitchOn, 1'b1);
    chk(stat.biasRegulatorOn, 1'b0);
    chk(stat.highImpedanceState, 1'b1);
    $display("test reset done");
    // plug in while frozen: nothing may move until the enable returns
    @(posedge clock);
    clockEn <= 1'b0;
    pinsDrv.inputPresent <= 1'b1;
    pinsDrv.notSleep <= 1'b1;
    pinsDrv.minVoltOk <= 1'b0;
    settle(40);
    chk(stat.biasRegulatorOn, 1'b0);
    @(posedge clock);
    clockEn <= 1'b1;
    // weak source first: bias waits its delay, qualification retries
    biasAt = -1;
    nQual = 0;
    nInt = 0;
    for (i = 0; i < 80; i++) begin
      settle(1);
      if (biasAt < 0 && stat.biasRegulatorOn === 1'b1) biasAt = i;
      if (stat.qualLoadOn === 1'b1) nQual++;
      if (stat.intPulse === 1'b1) nInt++;
    end
    chk(biasAt >= 20, 1'b1);
    chk(nQual, 2);
    chk(stat.inputGoodFlag, 1'b0);
    @(posedge clock);
    pinsDrv.minVoltOk <= 1'b1;
    for (i = 0; i < 100 && stat.converterOn !== 1'b1; i++) begin
      settle(1);
      if (stat.intPulse === 1'b1) nInt++;
    end
    chk(i < 100, 1'b1);
    chk(nInt, 2);
    chk(stat.inputGoodFlag, 1'b1);
    chk(stat.powerGoodFlag, 1'b1);
    chk(stat.sourceTypeField, SRC_USB);
    chk(stat.inputCurrentLimit, ICL_USB);
    chk(stat.batterySwitchOn, 1'b1);
    chk(stat.chargeActive, 1'b1);
    chk(stat.pfmMode, 1'b0);
    $display("test power-up done");
    @(posedge clock);
    usbHost <= 1'b0;
    settle(10);
    chk(stat.sourceTypeField, SRC_ADAPT);
    chk(stat.inputCurrentLimit, ICL_ADAPT);
    strobe(0, 6'h0a);
    chk(stat.effCurrentLimit, 6'h0a);
    @(posedge clock);
    pinsDrv.sysAbove <= 1'b0;
    settle(8);
    chk(stat.effCurrentLimit, ICL_SOFT);
    @(posedge clock);
    pinsDrv.sysAbove <= 1'b1;
    strobe(1, 6'h30);
    chk(stat.inputVoltageLimit, 6'h30);
    chk(stat.effVoltageLimit, 6'h30);
    // overcurrent latches the switch open until re-enabled
    @(posedge clock);
    pinsDrv.batOcp <= 1'b1;
    settle(6);
    chk(stat.batterySwitchOffFlag, 1'b1);
    chk(stat.batterySwitchOn, 1'b0);
    @(posedge clock);
    pinsDrv.batOcp <= 1'b0;
    settle(6);
    chk(stat.batterySwitchOn, 1'b0);
    strobe(3, 6'h00);
    chk(stat.batterySwitchOffFlag, 1'b0);
    chk(stat.batterySwitchOn, 1'b1);
    $display("test limits done");
    // host mode: pin waits for force-detect; restarted 50-cycle timer then lapses
    strobe(2, 6'h00);
    chk(stat.hostTimeoutFlag, 1'b0);
    @(posedge clock);
    usbHost <= 1'b1;
    settle(10);
    chk(stat.inputCurrentLimit, 6'h0a);
    strobe(4, 6'h00);
    chk(stat.inputCurrentLimit, ICL_USB);
    chk(stat.sourceTypeField, SRC_USB);
    strobe(0, 6'h0b);
    @(posedge clock);
    cfgDrv.chargeEnable <= 1'b0;
    cfgDrv.limitTrackingOffset <= 2'h3;
    cfgDrv.batterySwitchDelay <= 1'b1;
    batV <= 6'h2e;
    strobe(5, 6'h00);
    chk(stat.batterySwitchOn, 1'b0);
    chk(stat.pfmMode, 1'b1);
    chk(stat.effVoltageLimit, 6'h2e + TRK_OFF3);
    strobe(2, 6'h00);
    settle(30);
    chk(stat.hostTimeoutFlag, 1'b0);
    settle(40);
    cfgExp = CFG_RST;
    cfgExp.batterySwitchDelay = 1'b1;
    chk(stat.hostTimeoutFlag, 1'b1);
    chk(cfg, cfgExp);
    chk(stat.inputCurrentLimit, 6'h0b);
    chk(stat.inputVoltageLimit, 6'h30);
    chk(stat.chargeActive, 1'b1);
    settle(200);
    chk(stat.chargeActive, 1'b0);
    chk(stat.converterOn, 1'b1);
    $display("test keep-alive done");
    // battery only, then boost: delay, pulse phase, fixed phase, exit
    @(posedge clock);
    pinsDrv.inputPresent <= 1'b0;
    pinsDrv.notSleep <= 1'b0;
    settle(8);
    chk(stat.biasRegulatorOn, 1'b0);
    chk(stat.batterySwitchOn, 1'b1);
    chk(stat.powerGoodFlag, 1'b0);
    @(posedge clock);
    cfgDrv.boostEnable <= 1'b1;
    cfgDrv.boostCurrentSelect <= 1'b1;
    strobe(5, 6'h00);
    for (i = 0; i < 50 && stat.boostOn !== 1'b1; i++) settle(1);
    chk(i >= 8 && i < 50, 1'b1);
    chk(stat.sourceTypeField, SRC_BOOST);
    chk(stat.boostCurrentSelect, 1'b1);
    chk(stat.pfmMode, 1'b1);
    settle(20);
    chk(stat.boostOn, 1'b1);
    chk(stat.pfmMode, 1'b0);
    @(posedge clock);
    pinsDrv.batAboveBoost <= 1'b0;
    settle(8);
    chk(stat.boostOn, 1'b0);
    $display("test boost done");
    complete_run();
  end
endmodule
